// File: rucl_regs.svh
// register offsets, field positions, field widths and codes of the loader
// assumes inclusion by bare name from the package and the design files
`ifndef RUCL_REGS_SVH
`define RUCL_REGS_SVH

`define RUCL_CTRL_OFS      8'h00
`define RUCL_CMD_OFS       8'h04
`define RUCL_STATUS_OFS    8'h08

`define RUCL_PAGE_W        8
`define RUCL_TMO_W         12
`define RUCL_CTRL_PAGE_LSB 0
`define RUCL_CTRL_WDEN_BIT 8
`define RUCL_CTRL_TMO_LSB  16

`define RUCL_CMD_START_BIT 0
`define RUCL_CMD_FACT_BIT  1
`define RUCL_CMD_KICK_BIT  2

`define RUCL_ST_CAUSE_LSB  0
`define RUCL_ST_APP_BIT    4
`define RUCL_ST_BUSY_BIT   5
`define RUCL_ST_WDON_BIT   6
`define RUCL_ST_PAGE_LSB   8

`define RUCL_CAUSE_NONE    2'h0
`define RUCL_CAUSE_WD      2'h1
`define RUCL_CAUSE_LOADERR 2'h2
`define RUCL_CAUSE_USER    2'h3

`define RUCL_HSIZE_WORD    3'h2
`define RUCL_WD_CNT_W      20

`endif

// File: rucl_pkg.sv
// types of the remote update loader: states and the state records of loader and watchdog
// assumes rucl_regs.svh is on the include path
`include "rucl_regs.svh"

package rucl_pkg;

    typedef enum logic [1:0] {
        S_LOAD_FACT,
        S_FACTORY,
        S_LOAD_APP,
        S_APP
    } rucl_state_t;

    typedef struct packed {
        rucl_state_t             st;
        logic [`RUCL_PAGE_W-1:0] ctrl_page;
        logic                    ctrl_wden;
        logic [`RUCL_TMO_W-1:0]  ctrl_tmo;
        logic [`RUCL_PAGE_W-1:0] act_page;
        logic                    act_wden;
        logic [`RUCL_TMO_W-1:0]  act_tmo;
        logic                    ru_img;
        logic [1:0]              cause;
        logic                    req;
        logic                    fact;
        logic                    kick;
        logic                    wd_on;
        logic                    app;
        logic                    rdy;
        logic                    wr_pend;
        logic [7:0]              wr_addr;
        logic [31:0]             hrdata;
        logic [2:0]              s1;
        logic [2:0]              s2;
    } rucl_top_t;

    typedef struct packed {
        logic [`RUCL_WD_CNT_W-1:0] cnt;
        logic                      expired;
    } rucl_wd_t;

endpackage

// File: rucl_wdog.sv
// user watchdog counter: counts down while enabled, reloads on restart
// assumes enable, restart and setting come from logic on the same clock
`timescale 1ns/1ps
`include "rucl_regs.svh"

module rucl_wdog #(
    parameter int CNT_W = `RUCL_WD_CNT_W,
    parameter int SET_W = `RUCL_TMO_W
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic             en_in,
    input  wire logic             kick_in,
    input  wire logic [SET_W-1:0] setting_in,
    output logic                  expired_out
);

    if (CNT_W != `RUCL_WD_CNT_W || SET_W >= CNT_W) begin
        $error("rucl_wdog: unsupported widths");
    end

    rucl_pkg::rucl_wd_t r;
    rucl_pkg::rucl_wd_t n;
    logic [CNT_W-1:0]   load;

    assign load = {setting_in, {(CNT_W-SET_W){1'b0}}};

    always_comb begin
        n = r;
        n.expired = 1'b0;
        if (!en_in || kick_in) begin
            n.cnt = load;
        end else if (r.cnt == '0) begin
            n.expired = 1'b1;
            n.cnt = load;
        end else begin
            n.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign expired_out = r.expired;

    property p_wd_quiet;
        @(posedge clock_in) disable iff (rst_in)
        !en_in |=> !expired_out;
    endproperty
    a_wd_quiet: assert property (p_wd_quiet) else $error("watchdog fired while off"); // RULE_07

endmodule

// File: rucl_loader.sv
// remote update loader: ahb-lite registers, load sequencing, watchdog
// assumes a configuration memory with a four-phase req / done|error link
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rucl_regs.svh"

// How it works
// RULE_01: in factory mode a start command loads the page held in the control register.
// RULE_02: the watchdog enable for the next application is taken from the control register.
// RULE_03: the watchdog timeout is taken from the control register at the same moment.
// RULE_04: application logic must keep restarting the watchdog before it runs out.
// RULE_05: restarts count only when the loaded image is marked as built for remote update.
// RULE_06: a watchdog expiry records its cause in status and starts a factory load.
// RULE_07: the watchdog is off whenever the application is not the running image.
// RULE_08: an application load error records its cause in status.
// RULE_09: after a load error the factory image is loaded with no outside help.
// RULE_10: factory logic reads status and then writes control with the next page.
// RULE_11: a clean application load enters user mode running that application.
// RULE_12: update logic stores the new image and then requests a factory load.
// RULE_13: watchdog timeout and load error have different status codes.
module rucl_loader (
    input  wire logic                    clock_in,
    input  wire logic                    rst_in,
    input  wire logic                    hsel_in,
    input  wire logic [31:0]             haddr_in,
    input  wire logic [1:0]              htrans_in,
    input  wire logic                    hwrite_in,
    input  wire logic [2:0]              hsize_in,
    input  wire logic [31:0]             hwdata_in,
    input  wire logic                    hready_in,
    output logic [31:0]                  hrdata_out,
    output logic                         hreadyout_out,
    output logic                         hresp_out,
    input  wire logic                    cfg_done_in,
    input  wire logic                    cfg_error_in,
    input  wire logic                    cfg_ru_image_in,
    output logic                         cfg_req_out,
    output logic                         cfg_factory_out,
    output logic [`RUCL_PAGE_W-1:0]      cfg_page_out,
    output logic                         user_mode_out,
    output logic                         wd_active_out
);

    localparam rucl_pkg::rucl_top_t RST = '{
        st: rucl_pkg::S_LOAD_FACT, fact: 1'b1, rdy: 1'b1, default: '0};

    rucl_pkg::rucl_top_t r;
    rucl_pkg::rucl_top_t n;
    logic                done_s;
    logic                err_s;
    logic                ru_s;
    logic                ld_end;
    logic                acc;
    logic                cmd_wr;
    logic                start_app;
    logic                go_fact;
    logic                kick_ok;
    logic                wd_exp;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        is_reg = (a == ofs);
    endfunction

    assign done_s    = r.s2[0];
    assign err_s     = r.s2[1];
    assign ru_s      = r.s2[2];
    assign ld_end    = r.req && (done_s || err_s);
    assign acc       = hsel_in && hready_in && htrans_in[1];
    assign cmd_wr    = r.wr_pend && is_reg(r.wr_addr, `RUCL_CMD_OFS);
    assign start_app = cmd_wr && hwdata_in[`RUCL_CMD_START_BIT] && r.st == rucl_pkg::S_FACTORY;
    assign go_fact   = cmd_wr && hwdata_in[`RUCL_CMD_FACT_BIT] && r.st == rucl_pkg::S_APP;
    assign kick_ok   = cmd_wr && hwdata_in[`RUCL_CMD_KICK_BIT] && r.st == rucl_pkg::S_APP
                       && r.ru_img; // RULE_05

    rucl_wdog #(
        .CNT_W (`RUCL_WD_CNT_W),
        .SET_W (`RUCL_TMO_W)
    ) u_wdog (
        .clock_in    (clock_in),
        .rst_in      (rst_in),
        .en_in       (r.wd_on),
        .kick_in     (r.kick),
        .setting_in  (r.act_tmo),
        .expired_out (wd_exp)
    );

    always_comb begin
        n = r;
        n.s1 = {cfg_ru_image_in, cfg_error_in, cfg_done_in};
        n.s2 = r.s1;
        n.kick = kick_ok;
        n.wr_pend = 1'b0;
        if (acc) begin
            n.wr_pend = hwrite_in && hsize_in == `RUCL_HSIZE_WORD;
            n.wr_addr = haddr_in[7:0];
            n.hrdata = '0;
            if (!hwrite_in && is_reg(haddr_in[7:0], `RUCL_CTRL_OFS)) begin
                n.hrdata[`RUCL_CTRL_PAGE_LSB +: `RUCL_PAGE_W] = r.ctrl_page;
                n.hrdata[`RUCL_CTRL_WDEN_BIT] = r.ctrl_wden;
                n.hrdata[`RUCL_CTRL_TMO_LSB +: `RUCL_TMO_W] = r.ctrl_tmo;
            end else if (!hwrite_in && is_reg(haddr_in[7:0], `RUCL_STATUS_OFS)) begin
                n.hrdata[`RUCL_ST_CAUSE_LSB +: 2] = r.cause;
                n.hrdata[`RUCL_ST_APP_BIT] = r.app;
                n.hrdata[`RUCL_ST_BUSY_BIT] = r.st == rucl_pkg::S_LOAD_FACT
                                              || r.st == rucl_pkg::S_LOAD_APP;
                n.hrdata[`RUCL_ST_WDON_BIT] = r.wd_on;
                n.hrdata[`RUCL_ST_PAGE_LSB +: `RUCL_PAGE_W] = r.act_page;
            end
        end
        if (r.wr_pend && is_reg(r.wr_addr, `RUCL_CTRL_OFS)) begin
            n.ctrl_page = hwdata_in[`RUCL_CTRL_PAGE_LSB +: `RUCL_PAGE_W];
            n.ctrl_wden = hwdata_in[`RUCL_CTRL_WDEN_BIT];
            n.ctrl_tmo = hwdata_in[`RUCL_CTRL_TMO_LSB +: `RUCL_TMO_W];
        end
        case (r.st)
            rucl_pkg::S_LOAD_FACT: begin
                if (!r.req && !(done_s || err_s)) begin
                    n.req = 1'b1;
                end else if (ld_end) begin
                    n.req = 1'b0;
                    if (!err_s) begin
                        n.st = rucl_pkg::S_FACTORY;
                    end
                end
            end
            rucl_pkg::S_FACTORY: begin
                if (start_app) begin
                    n.act_page = r.ctrl_page; // RULE_01
                    n.act_wden = r.ctrl_wden; // RULE_02
                    n.act_tmo = r.ctrl_tmo; // RULE_03
                    n.fact = 1'b0;
                    n.st = rucl_pkg::S_LOAD_APP;
                end
            end
            rucl_pkg::S_LOAD_APP: begin
                if (!r.req && !(done_s || err_s)) begin
                    n.req = 1'b1;
                end else if (ld_end) begin
                    n.req = 1'b0;
                    if (err_s) begin
                        n.cause = `RUCL_CAUSE_LOADERR; // RULE_08 RULE_13
                        n.fact = 1'b1; // RULE_09
                        n.st = rucl_pkg::S_LOAD_FACT; // RULE_09
                    end else begin
                        n.ru_img = ru_s; // RULE_05
                        n.st = rucl_pkg::S_APP; // RULE_11
                    end
                end
            end
            rucl_pkg::S_APP: begin
                if (wd_exp) begin
                    n.cause = `RUCL_CAUSE_WD; // RULE_06 RULE_13
                    n.fact = 1'b1; // RULE_06
                    n.st = rucl_pkg::S_LOAD_FACT; // RULE_06
                end else if (go_fact) begin
                    n.cause = `RUCL_CAUSE_USER;
                    n.fact = 1'b1;
                    n.st = rucl_pkg::S_LOAD_FACT;
                end
            end
            default: begin
                n.st = rucl_pkg::S_LOAD_FACT;
            end
        endcase
        n.app = n.st == rucl_pkg::S_APP; // RULE_11
        n.wd_on = n.st == rucl_pkg::S_APP && n.act_wden; // RULE_07
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    assign hrdata_out      = r.hrdata;
    assign hreadyout_out   = r.rdy;
    assign hresp_out       = 1'b0;
    assign cfg_req_out     = r.req;
    assign cfg_factory_out = r.fact;
    assign cfg_page_out    = r.act_page;
    assign user_mode_out   = r.app;
    assign wd_active_out   = r.wd_on;

    property p_page_taken;
        @(posedge clock_in) disable iff (rst_in)
        start_app |=> r.st == rucl_pkg::S_LOAD_APP && cfg_page_out == $past(r.ctrl_page)
                      && !cfg_factory_out;
    endproperty
    a_page_taken: assert property (p_page_taken) else $error("page not taken"); // RULE_01

    property p_wden_taken;
        @(posedge clock_in) disable iff (rst_in)
        start_app |=> r.act_wden == $past(r.ctrl_wden) ##0 !wd_active_out;
    endproperty
    a_wden_taken: assert property (p_wden_taken) else $error("wd enable not taken"); // RULE_02

    property p_tmo_taken;
        @(posedge clock_in) disable iff (rst_in)
        start_app && r.ctrl_wden |=> r.act_tmo == $past(r.ctrl_tmo);
    endproperty
    a_tmo_taken: assert property (p_tmo_taken) else $error("timeout not taken"); // RULE_03

    property p_kick_gate;
        @(posedge clock_in) disable iff (rst_in)
        cmd_wr && hwdata_in[`RUCL_CMD_KICK_BIT] && !r.ru_img |=> !r.kick;
    endproperty
    a_kick_gate: assert property (p_kick_gate) else $error("restart from plain image"); // RULE_05

    property p_wd_expiry;
        @(posedge clock_in) disable iff (rst_in)
        wd_exp && r.st == rucl_pkg::S_APP |=> r.cause == `RUCL_CAUSE_WD && cfg_factory_out
        ##1 (cfg_req_out || done_s || err_s);
    endproperty
    a_wd_expiry: assert property (p_wd_expiry) else $error("expiry not handled"); // RULE_06

    property p_wd_off;
        @(posedge clock_in) disable iff (rst_in)
        r.st != rucl_pkg::S_APP |-> !wd_active_out;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog on outside app"); // RULE_07

    property p_load_err;
        @(posedge clock_in) disable iff (rst_in)
        r.st == rucl_pkg::S_LOAD_APP && ld_end && err_s |=>
        r.cause == `RUCL_CAUSE_LOADERR && r.st == rucl_pkg::S_LOAD_FACT;
    endproperty
    a_load_err: assert property (p_load_err) else $error("load error not recorded"); // RULE_08

    property p_auto_fact;
        @(posedge clock_in) disable iff (rst_in)
        r.st == rucl_pkg::S_LOAD_APP && ld_end && err_s |=> cfg_factory_out && !cfg_req_out
        ##[1:4] cfg_req_out;
    endproperty
    a_auto_fact: assert property (p_auto_fact) else $error("no factory reload"); // RULE_09

    property p_user_mode;
        @(posedge clock_in) disable iff (rst_in)
        r.st == rucl_pkg::S_LOAD_APP && ld_end && !err_s |=> user_mode_out
        && wd_active_out == r.act_wden;
    endproperty
    a_user_mode: assert property (p_user_mode) else $error("user mode not entered"); // RULE_11

    property p_codes;
        @(posedge clock_in) disable iff (rst_in)
        r.st == rucl_pkg::S_LOAD_APP && ld_end && err_s |=> r.cause != `RUCL_CAUSE_WD;
    endproperty
    a_codes: assert property (p_codes) else $error("cause codes collide"); // RULE_13

endmodule

// File: rucl_cfgmem.sv
// configuration memory model: answers load requests on a four-phase link
// assumes the loader's request, factory flag and page come from its clock domain
`timescale 1ns/1ps

module rucl_cfgmem (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       req_in,
    input  wire logic       factory_in,
    input  wire logic [7:0] page_in,
    input  wire logic       err_app_in,
    input  wire logic       ru_in,
    input  wire logic [7:0] dly_in,
    output logic            done_out,
    output logic            error_out,
    output logic            ru_image_out,
    output logic [7:0]      page_out
);
    logic [7:0] cnt_ff;

    // answer after dly_in cycles, drop only once the request is gone
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff    <= 8'h00;
            done_out  <= 1'b0;
            error_out <= 1'b0;
            page_out  <= 8'h00;
        end else if (!req_in) begin
            cnt_ff    <= 8'h00;
            done_out  <= 1'b0;
            error_out <= 1'b0;
        end else if (!done_out && !error_out) begin
            if (cnt_ff == dly_in) begin
                // only application loads can fail
                error_out <= !factory_in && err_app_in;
                done_out  <= factory_in || !err_app_in;
                // page of the last application image fetched
                if (!factory_in) begin
                    page_out <= page_in;
                end
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    // image flag only meaningful beside done
    assign ru_image_out = done_out ? ru_in : ~ru_in;
endmodule

// File: tb_top.sv
// testbench of the remote update loader over ahb-lite
// assumes the configuration memory model beside it
`timescale 1ns/1ps
`include "rucl_regs.svh"

module tb_top;
    typedef struct packed {
        logic [7:0]  page;
        logic        wden;
        logic [11:0] tmo;
        logic        ru;
        logic        err;
        logic [7:0]  dly;
        logic [1:0]  cause;
    } rucl_row_t;

    logic clock_in = 1'b0, rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic hready, hresp, done, error, ru_img, req, fact, user, wd;
    logic err_app = 1'b0, ru = 1'b0;
    logic [7:0]  dly = 8'h02, page, mem_page;
    int          err_total = 0, num_checks = 0, i;
    rucl_row_t   rows [4] = '{'{8'h5A, 1'b0, 12'h000, 1'b1, 1'b0, 8'h01, `RUCL_CAUSE_NONE},
                              '{8'hFF, 1'b1, 12'h0FF, 1'b1, 1'b0, 8'h14, `RUCL_CAUSE_USER},
                              '{8'h00, 1'b0, 12'h000, 1'b0, 1'b1, 8'h03, `RUCL_CAUSE_LOADERR},
                              '{8'h01, 1'b1, 12'hFFF, 1'b0, 1'b1, 8'h0C, `RUCL_CAUSE_LOADERR}};

    always #2 clock_in = ~clock_in;

    rucl_loader DUT (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(`RUCL_HSIZE_WORD),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .cfg_done_in(done),
        .cfg_error_in(error), .cfg_ru_image_in(ru_img), .cfg_req_out(req),
        .cfg_factory_out(fact), .cfg_page_out(page), .user_mode_out(user),
        .wd_active_out(wd));

    rucl_cfgmem mem (.clock_in(clock_in), .rst_in(rst_in), .req_in(req), .factory_in(fact),
        .page_in(page), .err_app_in(err_app), .ru_in(ru), .dly_in(dly),
        .done_out(done), .error_out(error), .ru_image_out(ru_img), .page_out(mem_page));

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd_v);
        @(posedge clock_in);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge clock_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd_v;
        do @(posedge clock_in); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task wait_fact;
        for (i = 0; i < 100; i++) begin
            bus(1'b0, `RUCL_STATUS_OFS, 32'h0);
            if (rd[5:4] === 2'h0) break;
        end
        chk("wd_fact", 32'(wd), 32'h0);
    endtask

    task start_app(input logic [7:0] pg, input logic en, input logic [11:0] tm);
        bus(1'b1, `RUCL_CTRL_OFS, {4'h0, tm, 7'h0, en, pg});
        bus(1'b1, `RUCL_CMD_OFS, 32'h1);
    endtask

    task wd_run(input logic ru_v);
        wait_fact();
        ru      <= ru_v;
        err_app <= 1'b0;
        start_app(8'h33, 1'b1, 12'h002);
        for (i = 0; i < 100 && user !== 1'b1; i++) @(posedge clock_in);
        repeat (5) begin
            repeat (150) @(posedge clock_in);
            bus(1'b1, `RUCL_CMD_OFS, 32'h4);
        end
    endtask

    task test_done;
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        foreach (rows[k]) begin
            wait_fact();
            err_app <= rows[k].err;
            ru      <= rows[k].ru;
            dly     <= rows[k].dly;
            start_app(rows[k].page, rows[k].wden, rows[k].tmo);
            for (i = 0; i < 50 && req !== 1'b1; i++) @(posedge clock_in);
            chk("factory", 32'(fact), 32'h0);
            chk("page", 32'(page), 32'(rows[k].page));
            for (i = 0; i < 200 && req !== 1'b0; i++) @(posedge clock_in);
            repeat (2) @(posedge clock_in);
            bus(1'b0, `RUCL_STATUS_OFS, 32'h0);
            chk("cause", 32'(rd[1:0]), 32'(rows[k].cause));
            if (rows[k].err) begin
                chk("refact", 32'(fact), 32'h1);
                chk("wd_err", 32'(wd), 32'h0);
            end else begin
                chk("user", 32'(user), 32'h1);
                chk("wd_on", 32'(wd), 32'(rows[k].wden));
                chk("st_page", 32'(rd[15:8]), 32'(rows[k].page));
                chk("st_bits", 32'(rd[6:4]), 32'({rows[k].wden, 2'b01}));
                chk("mem_page", 32'(mem_page), 32'(rows[k].page));
                bus(1'b1, `RUCL_CMD_OFS, 32'h2);
            end
        end
        wd_run(1'b1);
        chk("kept", 32'(user), 32'h1);
        for (i = 0; i < 700 && user !== 1'b0; i++) @(posedge clock_in);
        bus(1'b0, `RUCL_STATUS_OFS, 32'h0);
        chk("cause_wd", 32'(rd[1:0]), 32'(`RUCL_CAUSE_WD));
        chk("wd_fact", 32'(fact), 32'h1);
        chk("wd_off", 32'(wd), 32'h0);
        wd_run(1'b0);
        chk("no_ru", 32'(user), 32'h0);
        bus(1'b0, `RUCL_STATUS_OFS, 32'h0);
        chk("cause_nr", 32'(rd[1:0]), 32'(`RUCL_CAUSE_WD));
        bus(1'b0, `RUCL_CTRL_OFS, 32'h0);
        chk("ctrl_rd", rd, 32'h00020133);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b0, `RUCL_CMD_OFS, 32'h0);
        chk("cmd_rd", rd, 32'h0);
        rst_in <= 1'b1;
        @(posedge clock_in);
        #1;
        chk("rst_rdy", 32'(hready), 32'h1);
        chk("rst_req", 32'(req), 32'h0);
        chk("rst_fact", 32'({fact, user, wd, hresp}), 32'h8);
        @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        chk("rel_req", 32'({req, fact}), 32'h3);
        wait_fact();
        test_done();
    end
endmodule
